// file: src/ucc_main_ctrl.sv
/*
 Per-channel control registers and control logic of a quad upconverter.
 Assumes host strobes are on mclk; gate pin and hardware strobes that are not
 arrive through this block's own synchronisers; datapath inputs are on mclk.
*/
// Functional notes
// (R1) Lower trim bit removes two edge latencies from the gate delay path.
// (R2) Host pairs shortened latency with data span 3 and interpolation 4.
// (R3) Upper trim bit bypasses alignment; raw gate feeds the channel.
// (R4) Seven-bit length field is the highest ramp memory address used.
// (R5) Immediate bit clear: slaves update only on masked synchronous updates.
// (R6) Immediate bit set: host write loads slave after 4-clock synchronisation.
// (R7) Ramp hold gives host ramp memory, freezes last address and gain.
// (R8) Releasing ramp hold returns output to current ramp address and value.
// (R9) Delay select inserts half coarse-sample delay after shaping filter.
// (R10) Coefficient hold hands coefficient memories to host, else hardware owns.
// (R11) Gate-source bit selects internal gate generator, default external pin.
// (R12) Three-bit threshold sets almost-empty level for both I and Q FIFOs.
// (R13) Complex output swaps real sums for imaginary sums on channels 0 and 2.
// (R14) Offline forces FIFO read address zero; drained flag after flushing.
// (R15) Input-enable gates hardware transmit-enable and update inputs.
// (R16) Output-enable clear drives channel output data to zero.
// (R17) Serial-gate-disable keeps serial input block running regardless of gate.
// (R18) With serial gating off, the source feeds zeros while gate low.
// (R19) Gate rising edge flushes channel and filter memory unless suppressed.
// (R20) Parallel-mode FIFO overflow resets channel unless disabled.
// (R21) Software transmit rising edge flushes 16 clocks and masks an update.
// (R22) Software transmit high permits serial requests; low stops them.
// (R23) Gain-ramp mode slews gain through ramp memory on gate transitions.
// (R24) Each channel keeps its own registers; reads return last writes.
`timescale 1ns/100ps

module ucc_main_ctrl
	import ucc_pkg::*;
#(
	parameter int CHANNEL_ID = 0,
	parameter int DW = 20
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// host register port
	input wire ucc_pkg::ucc_host_t host,
	output logic [15:0] host_rdata,
	// gate and hardware strobes from pins
	input wire logic gate_pin,
	input wire logic hw_tx_enable,
	input wire logic hw_update,
	// datapath inputs on mclk
	input wire logic gate_internal_gen,
	input wire logic gain_ramp_mode,
	input wire logic parallel_mode,
	input wire logic fifo_overflow,
	input wire logic [DW-1:0] chan_data,
	input wire logic [DW-1:0] real_partial_sum_two,
	input wire logic [DW-1:0] imag_partial_sum_one,
	input wire logic [DW-1:0] real_partial_sum_four,
	input wire logic [DW-1:0] imag_partial_sum_three,
	input wire logic [DW-1:0] other_sum,
	// control outputs
	output ucc_pkg::ucc_ctl_t ctl,
	output logic [6:0] ramp_last_addr,
	output logic [6:0] ramp_addr,
	output logic channel_transmit_gate,
	output logic channel_drained_flag,
	output logic [DW-1:0] chan_out,
	output logic [DW-1:0] sum_out
);
	import ucc_pkg::*;

	typedef struct packed {
		logic [15:0] gr;
		logic [15:0] mc;
		logic [1:0] gp_s;
		logic [1:0] htx_s;
		logic [1:0] hup_s;
		logic [2:0] gdly;
		logic gate;
		logic gate_prev;
		logic swtx_prev;
		logic [4:0] flush_cnt;
		logic [4:0] off_cnt;
		logic drained;
		logic [UCC_SYNC_CLKS-1:0] imm_pipe;
		logic sync_upd;
		logic [6:0] raddr;
		logic rhold;
		logic [6:0] rfrozen;
		logic ramp_act;
		logic dly_ph;
		logic chrst;
		logic [DW-1:0] cout;
		logic [DW-1:0] sout;
		logic [15:0] rdata;
	} ucc_state_t;

	ucc_state_t s_q, s_d;

	logic hw_tx_ok;
	logic hw_up_ok;
	logic gate_src;
	logic gate_rise;
	logic gate_edge;
	logic swtx_rise;

	// accepted hardware strobes and gate selection
	always_comb
	begin
		hw_tx_ok = s_q.htx_s[1] & s_q.mc[UCC_MC_INEN_BIT]; // see (R15)
		hw_up_ok = s_q.hup_s[1] & s_q.mc[UCC_MC_INEN_BIT]; // see (R15)
		// internal generator or the pin, qualified by the hardware enable when input enable is set
		gate_src = (s_q.mc[UCC_MC_GSRC_BIT] ? gate_internal_gen : s_q.gp_s[1]) // see (R11)
			& (hw_tx_ok | ~s_q.mc[UCC_MC_INEN_BIT]);
		gate_rise = s_q.gate & ~s_q.gate_prev;
		gate_edge = s_q.gate ^ s_q.gate_prev;
		swtx_rise = s_q.mc[UCC_MC_SWTX_BIT] & ~s_q.swtx_prev;
	end

	// next-state logic
	always_comb
	begin
		s_d = s_q;
		// pin synchronisers: only stage 1 reads stage 0
		s_d.gp_s = {s_q.gp_s[0], gate_pin};
		s_d.htx_s = {s_q.htx_s[0], hw_tx_enable};
		s_d.hup_s = {s_q.hup_s[0], hw_update};

		// host writes; registers are per channel instance
		if (host.wr && host.addr == UCC_ADDR_GAIN_RAMP)
			s_d.gr = host.wdata; // see (R24)
		if (host.wr && host.addr == UCC_ADDR_MAIN_CTRL)
			s_d.mc = host.wdata; // see (R24)
		// registered read data, unmapped reads as zero
		unique case (host.addr)
			UCC_ADDR_GAIN_RAMP: s_d.rdata = s_q.gr; // see (R24)
			UCC_ADDR_MAIN_CTRL: s_d.rdata = s_q.mc;
			default: s_d.rdata = 16'h0000;
		endcase

		// gate alignment delay: three stages, one when shortened
		s_d.gdly = {s_q.gdly[1:0], gate_src};
		if (s_q.gr[UCC_GR_BYPASS_BIT])
			s_d.gate = gate_src; // see (R3)
		else if (s_q.gr[UCC_GR_SHORT_BIT])
			s_d.gate = s_q.gdly[0]; // see (R1)
		else
			s_d.gate = s_q.gdly[2];
		s_d.gate_prev = s_q.gate;
		s_d.swtx_prev = s_q.mc[UCC_MC_SWTX_BIT];

		// immediate update: host write shifts through a 4-clock pipe
		s_d.imm_pipe = {s_q.imm_pipe[UCC_SYNC_CLKS-2:0],
			host.wr & s_q.mc[UCC_MC_IMM_BIT]}; // see (R6)
		// masked synchronous update from hardware strobe or sw transmit edge
		s_d.sync_upd = (hw_up_ok | swtx_rise) & ~s_q.mc[UCC_MC_IMM_BIT]; // see (R5)
		if (swtx_rise)
			s_d.sync_upd = 1'b1; // see (R21)

		// flush counter: sw transmit edge and gate rising edge; a new edge restarts it
		if (swtx_rise)
			s_d.flush_cnt = 5'(UCC_SWTX_FLUSH_CLKS); // see (R21)
		else if (gate_rise && !s_q.mc[UCC_MC_FSUP_BIT])
			s_d.flush_cnt = 5'(UCC_GATE_FLUSH_CLKS); // see (R19)
		else if (s_q.flush_cnt != 5'h00)
			s_d.flush_cnt = s_q.flush_cnt - 5'h01;

		// offline flushing and drained flag
		if (s_q.mc[UCC_MC_ONL_BIT])
		begin
			s_d.off_cnt = 5'(UCC_OFFLINE_FLUSH_CLKS);
			s_d.drained = 1'b0;
		end
		else if (s_q.off_cnt != 5'h00)
			s_d.off_cnt = s_q.off_cnt - 5'h01;
		else
			s_d.drained = 1'b1; // see (R14)

		// ramp sequencer: walks 0..length on gate transitions in ramp mode
		s_d.rhold = s_q.mc[UCC_MC_RHOLD_BIT];
		if (s_q.mc[UCC_MC_RHOLD_BIT] && !s_q.rhold)
			s_d.rfrozen = s_q.raddr; // see (R7)
		if (!s_q.mc[UCC_MC_RHOLD_BIT])
		begin
			if (gain_ramp_mode && gate_edge)
				s_d.ramp_act = 1'b1; // see (R23)
			if (s_q.ramp_act)
			begin
				if (s_q.gate)
				begin
					if (s_q.raddr == s_q.gr[UCC_GR_LEN_LSB +: UCC_GR_LEN_W]) // see (R4)
						s_d.ramp_act = 1'b0;
					else
						s_d.raddr = s_q.raddr + 7'h01;
				end
				else if (s_q.raddr == 7'h00)
					s_d.ramp_act = 1'b0;
				else
					s_d.raddr = s_q.raddr - 7'h01;
			end
		end

		// half coarse-sample delay phase toggles each clock when selected
		s_d.dly_ph = s_q.mc[UCC_MC_DLY_BIT] & ~s_q.dly_ph; // see (R9)

		// parallel-mode overflow reset
		s_d.chrst = fifo_overflow & parallel_mode & ~s_q.mc[UCC_MC_OVRD_BIT]; // see (R20)

		// output data: zeroed when disabled or flushing
		s_d.cout = (s_q.mc[UCC_MC_OUTEN_BIT] && s_q.flush_cnt == 5'h00)
			? chan_data : '0; // see (R16)
		// complex steering on channels 0 and 2
		if (CHANNEL_ID == 0)
			s_d.sout = s_q.mc[UCC_MC_CPLX_BIT] ? imag_partial_sum_one
				: real_partial_sum_two; // see (R13)
		else if (CHANNEL_ID == 2)
			s_d.sout = s_q.mc[UCC_MC_CPLX_BIT] ? imag_partial_sum_three
				: real_partial_sum_four; // see (R13)
		else
			s_d.sout = other_sum;
	end

	// state register
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.gr <= UCC_GR_RESET;
			s_q.mc <= UCC_MC_RESET;
		end
		else
			s_q <= s_d;
	end

	// outputs; ctl fields are combinational decodes of registered state
	always_comb
	begin
		ctl.imm_update = s_q.imm_pipe[UCC_SYNC_CLKS-1]; // see (R6)
		ctl.sync_update = s_q.sync_upd; // see (R5)
		ctl.ramp_host_access = s_q.mc[UCC_MC_RHOLD_BIT]; // see (R7)
		ctl.coef_host_access = s_q.mc[UCC_MC_CHOLD_BIT]; // see (R10)
		ctl.half_delay = s_q.dly_ph; // see (R9)
		ctl.gate_internal = s_q.mc[UCC_MC_GSRC_BIT]; // see (R11)
		ctl.ae_threshold = s_q.mc[UCC_MC_THR_LSB +: 3]; // see (R12)
		ctl.fifo_rd_zero = ~s_q.mc[UCC_MC_ONL_BIT]; // see (R14)
		ctl.flush = s_q.flush_cnt != 5'h00; // see (R19)
		// serial block follows the gate unless gating is disabled
		ctl.serial_run = s_q.mc[UCC_MC_SGD_BIT] | s_q.gate; // see (R17)
		ctl.serial_req_en = s_q.mc[UCC_MC_SWTX_BIT]; // see (R22)
		ctl.chan_reset = s_q.chrst; // see (R20)
		ctl.ramp_active = s_q.ramp_act;
	end

	// on hold the ramp address reads frozen; on release it returns to live
	assign ramp_addr = s_q.rhold ? s_q.rfrozen : s_q.raddr; // see (R8)
	assign ramp_last_addr = s_q.rfrozen;
	assign channel_transmit_gate = s_q.gate;
	assign channel_drained_flag = s_q.drained;
	assign chan_out = s_q.cout;
	assign sum_out = s_q.sout;
	assign host_rdata = s_q.rdata;

	// gate path length matches the trim setting
	AST_BYPASS: assert property (@(posedge mclk) disable iff (reset) // see (R3)
		s_q.gr[UCC_GR_BYPASS_BIT] && $past(s_q.gr[UCC_GR_BYPASS_BIT]) |->
		s_q.gate == $past(gate_src))
		else $error("bypass gate mismatch");
	AST_SHORT: assert property (@(posedge mclk) disable iff (reset) // see (R1)
		(s_q.gr[8:7] == 2'b01) [*3] |-> s_q.gate == $past(gate_src, 2))
		else $error("short gate latency wrong");
	AST_IMM: assert property (@(posedge mclk) disable iff (reset) // see (R6)
		host.wr && s_q.mc[UCC_MC_IMM_BIT] |-> ##4 ctl.imm_update)
		else $error("immediate update not after 4 clocks");
	AST_SWTX_FLUSH: assert property (@(posedge mclk) disable iff (reset) // see (R21)
		swtx_rise |=> ctl.flush [*8] ##1 ctl.sync_update == 1'b0 || ctl.flush)
		else $error("sw transmit flush too short");
	AST_SYNC_MASK: assert property (@(posedge mclk) disable iff (reset) // see (R5)
		s_q.mc[UCC_MC_IMM_BIT] && !swtx_rise |=> !ctl.sync_update)
		else $error("sync update in immediate mode");
	AST_OUT_ZERO: assert property (@(posedge mclk) disable iff (reset) // see (R16)
		!s_q.mc[UCC_MC_OUTEN_BIT] |=> chan_out == '0)
		else $error("output not zeroed");
	AST_DRAIN: assert property (@(posedge mclk) disable iff (reset) // see (R14)
		$fell(s_q.mc[UCC_MC_ONL_BIT]) |-> !channel_drained_flag ##[20:30] channel_drained_flag)
		else $error("drained flag timing");
	AST_OVF: assert property (@(posedge mclk) disable iff (reset) // see (R20)
		fifo_overflow && !parallel_mode |=> !ctl.chan_reset)
		else $error("overflow reset outside parallel mode");
	AST_RAMP_LEN: assert property (@(posedge mclk) disable iff (reset) // see (R4)
		s_q.ramp_act && s_q.gate && !s_q.rhold && $stable(s_q.gr) |->
		s_q.raddr <= s_q.gr[6:0] || $past(s_q.raddr) == s_q.raddr)
		else $error("ramp beyond length");
	AST_HOLD: assert property (@(posedge mclk) disable iff (reset) // see (R7)
		s_q.rhold && $past(s_q.rhold) |-> $stable(ramp_addr))
		else $error("ramp address moved while held");
	AST_SERIAL: assert property (@(posedge mclk) disable iff (reset) // see (R17)
		s_q.mc[UCC_MC_SGD_BIT] |-> ctl.serial_run)
		else $error("serial block stopped");
endmodule

// file: src/ucc_pkg.sv
/*
 Package for the upconverter channel main control block: register offsets,
 field positions, reset values, timing counts and the carrier structs.
 Assumes a 16-bit host word and the 10 MHz mclk.
*/
package ucc_pkg;
	// register offsets (word addresses on the host bus)
	localparam logic [3:0] UCC_ADDR_GAIN_RAMP = 4'hb;
	localparam logic [3:0] UCC_ADDR_MAIN_CTRL = 4'hc;
	// gain_ramp_setup fields
	localparam int UCC_GR_LEN_LSB = 0;
	localparam int UCC_GR_LEN_W = 7;
	localparam int UCC_GR_SHORT_BIT = 7;
	localparam int UCC_GR_BYPASS_BIT = 8;
	// channel_main_control fields
	localparam int UCC_MC_IMM_BIT = 15;
	localparam int UCC_MC_RHOLD_BIT = 14;
	localparam int UCC_MC_DLY_BIT = 13;
	localparam int UCC_MC_CHOLD_BIT = 12;
	localparam int UCC_MC_GSRC_BIT = 11;
	localparam int UCC_MC_THR_LSB = 8;
	localparam int UCC_MC_CPLX_BIT = 7;
	localparam int UCC_MC_ONL_BIT = 6;
	localparam int UCC_MC_INEN_BIT = 5;
	localparam int UCC_MC_OUTEN_BIT = 4;
	localparam int UCC_MC_SGD_BIT = 3;
	localparam int UCC_MC_FSUP_BIT = 2;
	localparam int UCC_MC_OVRD_BIT = 1;
	localparam int UCC_MC_SWTX_BIT = 0;
	// reset values
	localparam logic [15:0] UCC_GR_RESET = 16'h0000;
	localparam logic [15:0] UCC_MC_RESET = 16'h0000;
	// timing counts in mclk cycles, then the channel count
	localparam int UCC_SYNC_CLKS = 4;
	localparam int UCC_SWTX_FLUSH_CLKS = 16;
	localparam int UCC_OFFLINE_FLUSH_CLKS = 24;
	localparam int UCC_GATE_FLUSH_CLKS = 16;
	localparam int UCC_CHANNELS = 4;

	// host access to the channel's registers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} ucc_host_t;

	// control outputs handed to the channel datapath
	typedef struct packed {
		logic imm_update;
		logic sync_update;
		logic ramp_host_access;
		logic coef_host_access;
		logic half_delay;
		logic gate_internal;
		logic [2:0] ae_threshold;
		logic fifo_rd_zero;
		logic flush;
		logic serial_run;
		logic serial_req_en;
		logic chan_reset;
		logic ramp_active;
	} ucc_ctl_t;
endpackage

// file: tb/ucc_host_model.sv
/*
 Host processor model: one-word writes and reads on the host struct.
 Assumes read data is registered one cycle after the address.
*/
`timescale 1ns/100ps
module ucc_host_model
	import ucc_pkg::*;
(
	// clock
	input wire logic mclk,
	// host bus
	output ucc_pkg::ucc_host_t host,
	input wire logic [15:0] rdata
);
	// released bus shows the inverted last address; writes also invert the data, reads keep it
	initial host = '0;
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1 host = '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		#1 host = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		#1 host = '{1'b0, 1'b1, a, host.wdata};
		@(posedge mclk);
		#1 d = rdata;
		host = '{1'b0, 1'b0, ~a, host.wdata};
	endtask
endmodule

// file: tb/upconverter_channel_main_control_test.sv
/*
 Self-checking bench for channel 0 control registers.
 Assumes the host model drives the host port; inputs move 1 ns after mclk rises.
*/
`timescale 1ns/100ps
module upconverter_channel_main_control_test;
	import ucc_pkg::*;
	logic mclk = 0, reset = 1, gpin = 0, hw_tx = 0, hw_upd = 0, par = 0, ovf = 0;
	logic gint = 0, grm = 0;
	logic [19:0] cd = 20'h12345, re2 = 20'h0a5a5, im1 = 20'h5a5a0, re4 = 20'h0f0f0;
	logic [19:0] im3 = 20'h70707, oth = 20'h33333, cout, sout;
	logic [15:0] rdata, d;
	logic [6:0] rl, ra;
	logic gate, drained;
	ucc_host_t host;
	ucc_ctl_t ctl;
	int miscompares = 0, checks = 0, cyc = 0, nsync = 0, nimm = 0, nrst = 0, st, ln;
	logic [15:0] vals [2] = '{16'h5b18, 16'h24f6};
	// 100 ns clock
	initial forever #50 mclk = ~mclk;
	ucc_host_model u_host (.mclk(mclk), .host(host), .rdata(rdata));
	ucc_main_ctrl #(.CHANNEL_ID(0), .DW(20)) u_dut (.mclk(mclk), .reset(reset), .host(host),
		.host_rdata(rdata), .gate_pin(gpin), .hw_tx_enable(hw_tx), .hw_update(hw_upd),
		.gate_internal_gen(gint), .gain_ramp_mode(grm), .parallel_mode(par),
		.fifo_overflow(ovf), .chan_data(cd), .real_partial_sum_two(re2),
		.imag_partial_sum_one(im1), .real_partial_sum_four(re4), .imag_partial_sum_three(im3),
		.other_sum(oth), .ctl(ctl), .ramp_last_addr(rl), .ramp_addr(ra),
		.channel_transmit_gate(gate), .channel_drained_flag(drained), .chan_out(cout),
		.sum_out(sout));
	// hang limit and pulse tallies; sampled at the edge so each high cycle counts once
	always @(posedge mclk)
	begin
		cyc++;
		nsync += (ctl.sync_update === 1'b1);
		nimm += (ctl.imm_update === 1'b1);
		nrst += (ctl.chan_reset === 1'b1);
		if (cyc == 4000)
		begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// bounded wait for flush, then its length
	task automatic flush_run();
		st = 0;
		ln = 0;
		while (ctl.flush !== 1'b1 && st < 20)
		begin
			tick(1);
			st++;
		end
		while (ctl.flush === 1'b1 && ln < 40)
		begin
			tick(1);
			ln++;
		end
	endtask
	task automatic t_reset();
		chk(ctl.fifo_rd_zero, 1); // offline
		chk(cout, 0); // output off
		u_host.rd(UCC_ADDR_GAIN_RAMP, d);
		chk(d, UCC_GR_RESET);
		u_host.rd(UCC_ADDR_MAIN_CTRL, d);
		chk(d, UCC_MC_RESET);
		tick(26);
		chk(drained, 1); // flushed
		$display("t_reset done");
	endtask
	task automatic t_regs();
		u_host.wr(UCC_ADDR_GAIN_RAMP, 16'h0155);
		u_host.wr(4'h0, 16'hffff);
		u_host.rd(UCC_ADDR_GAIN_RAMP, d);
		chk(d, 16'h0155);
		u_host.rd(4'h0, d);
		chk(d, 0); // unmapped
		foreach (vals[i])
		begin
			u_host.wr(UCC_ADDR_MAIN_CTRL, vals[i]);
			tick(3);
			u_host.rd(UCC_ADDR_MAIN_CTRL, d);
			chk(d, vals[i]);
			chk(ctl.ramp_host_access, vals[i][14]);
			chk(ctl.coef_host_access, vals[i][12]);
			chk(ctl.gate_internal, vals[i][11]);
			chk(ctl.ae_threshold, vals[i][10:8]);
			chk(ctl.fifo_rd_zero, !vals[i][6]);
			chk(ctl.serial_run, vals[i][3]); // gate low
			chk(cout, cd);
			chk(sout, vals[i][7] ? im1 : re2);
		end
		$display("t_regs done");
	endtask
	task automatic t_swtx();
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0040);
		tick(2);
		nsync = 0;
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0041);
		flush_run();
		chk(ln, UCC_SWTX_FLUSH_CLKS);
		chk(nsync, 1);
		chk(ctl.serial_req_en, 1);
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0041);
		flush_run();
		chk(ln, 0); // level only
		$display("t_swtx done");
	endtask
	task automatic t_imm();
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0040);
		nimm = 0;
		u_host.wr(UCC_ADDR_GAIN_RAMP, 16'h0012);
		tick(8);
		chk(nimm, 0);
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h8040);
		u_host.wr(UCC_ADDR_GAIN_RAMP, 16'h0013);
		st = 0;
		while (ctl.imm_update !== 1'b1 && st < 10)
		begin
			tick(1);
			st++;
		end
		// the write was taken one edge before the task returned
		chk(st + 1, UCC_SYNC_CLKS);
		$display("t_imm done");
	endtask
	task automatic t_gate(input logic [15:0] v, input int exp);
		u_host.wr(UCC_ADDR_MAIN_CTRL, v);
		tick(2);
		gpin = 1;
		flush_run();
		chk(ln, exp); // gate edge
		chk(gate, 1); // pin source
		chk(ctl.serial_run, 1);
		gpin = 0;
		tick(10);
		$display("t_gate done");
	endtask
	task automatic t_ovf(input logic [15:0] v, input logic p, input logic exp);
		u_host.wr(UCC_ADDR_MAIN_CTRL, v);
		par = p;
		nrst = 0;
		ovf = 1;
		tick(1);
		ovf = 0;
		tick(5);
		chk(nrst > 0, exp);
		$display("t_ovf done");
	endtask
	// ramp up on gate rise, freeze under hold, stay on release
	task automatic t_ramp();
		grm = 1;
		// short trim, length 3; host pairs it with data span 3 and interpolation 4
		u_host.wr(UCC_ADDR_GAIN_RAMP, 16'h0083);
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0040);
		gpin = 1;
		tick(20);
		chk(ra, 3);
		chk(ctl.ramp_active, 0);
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h4040);
		gpin = 0;
		tick(12);
		chk(ra, 3);
		chk(rl, 3);
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0040);
		tick(2);
		chk(ra, 3);
		grm = 0;
		$display("t_ramp done");
	endtask
	// internal gate, hardware strobes, delay phase, serial gating off
	task automatic t_hw();
		gint = 1;
		cd = 20'h00000; // zero data while gate low
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h2868);
		tick(12);
		chk(gate, 0); // no hw enable yet
		chk(ctl.serial_run, 1);
		st = ctl.half_delay;
		tick(1);
		chk(ctl.half_delay, st == 0);
		hw_tx = 1;
		tick(12);
		chk(gate, 1); // internal source
		cd = 20'h12345;
		nsync = 0;
		hw_upd = 1;
		tick(3);
		hw_upd = 0;
		tick(4);
		chk(nsync > 0, 1);
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0848);
		nsync = 0;
		hw_upd = 1;
		tick(3);
		hw_upd = 0;
		tick(4);
		chk(nsync, 0); // input disabled
		gint = 0;
		hw_tx = 0;
		tick(12);
		$display("t_hw done");
	endtask
	// going offline: drained only after the flush time
	task automatic t_drain();
		u_host.wr(UCC_ADDR_MAIN_CTRL, 16'h0000);
		tick(20);
		chk(drained, 0); // still flushing
		chk(ctl.fifo_rd_zero, 1);
		tick(6);
		chk(drained, 1);
		$display("t_drain done");
	endtask
	task automatic give_verdict();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// reset for two cycles, then the scenarios in turn
	initial
	begin
		repeat (2) @(posedge mclk);
		#1 reset = 0;
		t_reset();
		t_regs();
		t_swtx();
		t_imm();
		t_gate(16'h0040, UCC_GATE_FLUSH_CLKS);
		t_gate(16'h0044, 0);
		t_ovf(16'h0040, 1, 1);
		t_ovf(16'h0042, 1, 0);
		t_ovf(16'h0040, 0, 0);
		t_ramp();
		t_hw();
		t_drain();
		give_verdict();
	end
endmodule
